// File: trc_top.sv
// trc_top: up-counting timer with reload, tone and pwm outputs, apb registers
// Operation
// R1 - separate 8-bit write-only reload register
// R2 - overflow with autoload copies reload into count
// R3 - reload value is the pwm duty reference
// R4 - software sets reload before using tone
// R5 - reload register is write-only, reads zero
// R6 - reload register has no reset value
// R7 - width option fixes modulus; reload below N
// R8 - software loads N minus interval ticks
// R9 - count runs only while run enable set
// R10 - count increments once per selected tick
// R11 - fast select: codes divide oscillator 128 to 1
// R12 - 8-bit overflow on wrap FFH to 00H
// R13 - overflow sets sticky request flag
// R14 - without autoload software rewrites count
// R15 - tone toggles each overflow, takes the pin
// R16 - pwm low at reload match, high at zero
// R17 - narrow widths wrap N-1 to zero
module trc_top #(
	parameter int COUNT_BITS = trc_pkg::CNT_W         // counter width option: 8, 6, 5 or 4
) (
	input  wire logic        ref_clk,                 // 200 MHz oscillator clock
	input  wire logic        arst_n,                  // async reset, active low
	input  wire logic        psel,                    // apb select
	input  wire logic        penable,                 // apb enable
	input  wire logic        pwrite,                  // apb write
	input  wire logic [11:0] paddr,                   // apb byte address
	input  wire logic [31:0] pwdata,                  // apb write data
	output logic      [31:0] prdata,                  // apb read data
	output logic             pready,                  // apb ready
	output logic             pslverr,                 // apb error, unmapped address
	output logic             irq,                     // level interrupt
	output logic             tone_output,             // divided-by-two tone
	output logic             tone_oe,                 // tone owns the shared pin
	output logic             second_pwm_output        // pwm waveform
);

	// counter modulus and modulus minus one for the chosen width
	localparam int         N_MOD   = (COUNT_BITS == 8) ? trc_pkg::N_8BIT :
	                                 (COUNT_BITS == 6) ? trc_pkg::N_6BIT :
	                                 (COUNT_BITS == 5) ? trc_pkg::N_5BIT : trc_pkg::N_4BIT;
	localparam logic [7:0] CNT_MAX = 8'(N_MOD - 1);                               // R7

	trc_pkg::trc_apb_req_t req;
	trc_pkg::trc_apb_rsp_t rsp_ff;
	trc_pkg::trc_apb_rsp_t nxt_rsp;

	trc_pkg::trc_mode_t    mode_ff;
	trc_pkg::trc_mode_t    nxt_mode;
	logic [7:0]            count_ff;
	logic [7:0]            nxt_count;
	logic [7:0]            reload_ff;
	logic [7:0]            nxt_reload;
	logic [trc_pkg::NUM_EVENTS-1:0] irq_en_ff;
	logic [trc_pkg::NUM_EVENTS-1:0] nxt_irq_en;
	logic                  tone_ff;
	logic                  nxt_tone;
	logic                  tone_oe_ff;
	logic                  nxt_tone_oe;
	logic                  pwm_ff;
	logic                  nxt_pwm;
	logic                  irq_ff;
	logic                  nxt_irq;

	logic                  setup;
	logic                  wr_done;
	logic                  addr_ok;
	logic                  tick;
	logic                  overflow;
	logic                  duty_match;
	logic [7:0]            reload_eff;
	logic [7:0]            count_inc;
	logic [trc_pkg::NUM_EVENTS-1:0] evt_set;
	logic [trc_pkg::NUM_EVENTS-1:0] evt_clr;
	logic [trc_pkg::NUM_EVENTS-1:0] status;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	// bus decode: setup cycle loads answer, access completes one cycle later
	always_comb begin
		setup   = req.psel && !req.penable;
		wr_done = req.psel && req.penable && rsp_ff.pready && req.pwrite && !rsp_ff.pslverr;
		unique case (req.paddr)
			trc_pkg::ADDR_MODE,
			trc_pkg::ADDR_COUNT,
			trc_pkg::ADDR_STATUS,
			trc_pkg::ADDR_CLEAR,
			trc_pkg::ADDR_IRQ_EN,
			trc_pkg::ADDR_RELOAD: addr_ok = 1'b1;
			default:              addr_ok = 1'b0;
		endcase
	end

	// read mux and handshake
	always_comb begin
		nxt_rsp         = '0;
		nxt_rsp.pready  = setup;
		nxt_rsp.pslverr = setup && !addr_ok;
		if (setup && !req.pwrite) begin
			unique case (req.paddr)
				trc_pkg::ADDR_MODE: begin
					nxt_rsp.prdata[7:0] = mode_ff;
				end
				trc_pkg::ADDR_COUNT: begin
					nxt_rsp.prdata[7:0] = count_ff;
				end
				trc_pkg::ADDR_STATUS: begin
					nxt_rsp.prdata[trc_pkg::NUM_EVENTS-1:0] = status;
				end
				trc_pkg::ADDR_IRQ_EN: begin
					nxt_rsp.prdata[trc_pkg::NUM_EVENTS-1:0] = irq_en_ff;
				end
				default: begin
					nxt_rsp.prdata = '0;                                          // R5
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff <= nxt_rsp;
		end
	end

	// mode, interrupt enable and reload registers
	always_comb begin
		nxt_mode   = mode_ff;
		nxt_irq_en = irq_en_ff;
		nxt_reload = reload_ff;
		evt_clr    = '0;
		if (wr_done) begin
			unique case (req.paddr)
				trc_pkg::ADDR_MODE: begin
					nxt_mode = req.pwdata[7:0];
				end
				trc_pkg::ADDR_IRQ_EN: begin
					nxt_irq_en = req.pwdata[trc_pkg::NUM_EVENTS-1:0];
				end
				trc_pkg::ADDR_CLEAR: begin
					evt_clr = req.pwdata[trc_pkg::NUM_EVENTS-1:0];
				end
				trc_pkg::ADDR_RELOAD: begin
					nxt_reload = req.pwdata[7:0];                                 // R1
				end
				default: begin
					nxt_mode = mode_ff;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_ff   <= trc_pkg::MODE_RESET;
			irq_en_ff <= '0;
		end else begin
			mode_ff   <= nxt_mode;
			irq_en_ff <= nxt_irq_en;
		end
	end

	// no reset: contents are undefined until software writes them
	always_ff @(posedge ref_clk) begin
		reload_ff <= nxt_reload;                                                  // R6
	end

	trc_prescaler u_prescaler (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.run     (mode_ff.run),
		.fast    (mode_ff.fast),
		.rate    (mode_ff.rate),
		.tick    (tick)
	); // R10 R11

	// counter: software write wins over a tick in the same cycle
	always_comb begin
		reload_eff = reload_ff & CNT_MAX;                                         // R7
		count_inc  = count_ff + 8'h01;
		overflow   = 1'b0;
		duty_match = 1'b0;
		nxt_count  = count_ff;                                                    // R9
		if (wr_done && req.paddr == trc_pkg::ADDR_COUNT) begin
			nxt_count = req.pwdata[7:0] & CNT_MAX;                                // R17
		end else if (mode_ff.run && tick) begin                                  // R9
			if (count_ff == CNT_MAX) begin                                        // R12 R17
				overflow  = 1'b1;
				nxt_count = mode_ff.aload ? reload_eff : trc_pkg::ZERO8;         // R2
			end else begin
				nxt_count = count_inc & CNT_MAX;                                  // R10
			end
			duty_match = (nxt_count == reload_eff); // R3
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_ff <= trc_pkg::ZERO8;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// tone and pwm outputs
	always_comb begin
		nxt_tone_oe = mode_ff.tone_en;                                            // R15
		nxt_tone    = mode_ff.tone_en ? (tone_ff ^ overflow) : 1'b0;              // R15
		nxt_pwm     = pwm_ff;
		if (!mode_ff.pwm_en) begin
			nxt_pwm = 1'b0;
		end else begin
			if (overflow) begin
				nxt_pwm = 1'b1;                                                   // R16
			end
			if (duty_match) begin
				nxt_pwm = 1'b0;                                                   // R3 R16
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tone_ff    <= 1'b0;
			tone_oe_ff <= 1'b0;
			pwm_ff     <= 1'b0;
		end else begin
			tone_ff    <= nxt_tone;
			tone_oe_ff <= nxt_tone_oe;
			pwm_ff     <= nxt_pwm;
		end
	end

	// sticky event flags
	always_comb begin
		evt_set                          = '0;
		evt_set[trc_pkg::EVT_OVERFLOW]   = overflow;                              // R13
		evt_set[trc_pkg::EVT_DUTY_MATCH] = duty_match;
	end

	for (genvar i = 0; i < trc_pkg::NUM_EVENTS; i++) begin : g_flag
		trc_flag u_flag (
			.ref_clk (ref_clk),
			.arst_n  (arst_n),
			.set     (evt_set[i]),
			.clr     (evt_clr[i]),
			.flag    (status[i])
		); // R13
	end

	always_comb begin
		nxt_irq = |(status & irq_en_ff);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	assign prdata            = rsp_ff.prdata;
	assign pready            = rsp_ff.pready;
	assign pslverr           = rsp_ff.pslverr;
	assign irq               = irq_ff;
	assign tone_output       = tone_ff;
	assign tone_oe           = tone_oe_ff;
	assign second_pwm_output = pwm_ff;

endmodule : trc_top

// File: trc_pkg.sv
// trc_pkg: shared constants, register map and types for the reload timer
package trc_pkg;

	// register indices; the byte address is four times the index
	localparam logic [7:0]  IDX_MODE       = 8'hd8;
	localparam logic [7:0]  IDX_COUNT      = 8'hd9;
	localparam logic [7:0]  IDX_STATUS     = 8'hda;
	localparam logic [7:0]  IDX_CLEAR      = 8'hdb;
	localparam logic [7:0]  IDX_IRQ_EN     = 8'hdc;
	localparam logic [7:0]  IDX_RELOAD     = 8'hde;

	localparam int          ADDR_W         = 12;
	localparam logic [11:0] ADDR_MODE      = {2'h0, IDX_MODE, 2'h0};
	localparam logic [11:0] ADDR_COUNT     = {2'h0, IDX_COUNT, 2'h0};
	localparam logic [11:0] ADDR_STATUS    = {2'h0, IDX_STATUS, 2'h0};
	localparam logic [11:0] ADDR_CLEAR     = {2'h0, IDX_CLEAR, 2'h0};
	localparam logic [11:0] ADDR_IRQ_EN    = {2'h0, IDX_IRQ_EN, 2'h0};
	localparam logic [11:0] ADDR_RELOAD    = {2'h0, IDX_RELOAD, 2'h0};

	// mode register field positions
	localparam int          MODE_RUN_BIT   = 7;
	localparam int          MODE_RATE_HI   = 6;
	localparam int          MODE_RATE_LO   = 4;
	localparam int          MODE_FAST_BIT  = 3;
	localparam int          MODE_ALOAD_BIT = 2;
	localparam int          MODE_TONE_BIT  = 1;
	localparam int          MODE_PWM_BIT   = 0;

	// status / clear / enable layout
	localparam int          NUM_EVENTS     = 2;
	localparam int          EVT_OVERFLOW   = 0;
	localparam int          EVT_DUTY_MATCH = 1;

	// prescaler masks: slow path is fcpu = fosc/4 then /256, fast path fosc/128
	localparam int          PRE_W          = 10;
	localparam logic [9:0]  PRE_SLOW_MASK  = 10'h3ff;
	localparam logic [9:0]  PRE_FAST_MASK  = 10'h07f;

	// counter width option and moduli
	localparam int          CNT_W          = 8;
	localparam int          N_8BIT         = 256;
	localparam int          N_6BIT         = 64;
	localparam int          N_5BIT         = 32;
	localparam int          N_4BIT         = 16;

	localparam logic [7:0]  ZERO8          = 8'h00;
	localparam logic [9:0]  ZERO10         = 10'h000;

	typedef struct packed {
		logic       run;
		logic [2:0] rate;
		logic       fast;
		logic       aload;
		logic       tone_en;
		logic       pwm_en;
	} trc_mode_t;

	localparam trc_mode_t MODE_RESET = '{run: 1'b0, rate: 3'h0, fast: 1'b0,
		aload: 1'b0, tone_en: 1'b0, pwm_en: 1'b0};

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} trc_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} trc_apb_rsp_t;

endpackage : trc_pkg

// File: trc_prescaler.sv
// trc_prescaler: selectable divider producing the count tick
module trc_prescaler (
	input  wire logic              ref_clk,  // system clock (oscillator)
	input  wire logic              arst_n,   // async reset, active low
	input  wire logic              run,      // divider runs while high
	input  wire logic              fast,     // fast clock select
	input  wire logic [2:0]        rate,     // prescale select
	output logic                   tick      // one-cycle count tick
);

	logic [trc_pkg::PRE_W-1:0] div_ff;
	logic [trc_pkg::PRE_W-1:0] nxt_div;
	logic [trc_pkg::PRE_W-1:0] mask;

	// code 000 divides most, 111 least
	always_comb begin
		mask    = (fast ? trc_pkg::PRE_FAST_MASK : trc_pkg::PRE_SLOW_MASK) >> rate; // R11
		nxt_div = run ? div_ff + 10'h001 : trc_pkg::ZERO10;
		tick    = run && ((div_ff & mask) == mask);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_ff <= trc_pkg::ZERO10;
		end else begin
			div_ff <= nxt_div;
		end
	end

endmodule : trc_prescaler

// File: trc_flag.sv
// trc_flag: sticky event bit, set has priority over clear
module trc_flag (
	input  wire logic ref_clk,  // system clock
	input  wire logic arst_n,   // async reset, active low
	input  wire logic set,      // hardware event
	input  wire logic clr,      // software clear
	output logic      flag      // sticky flag
);

	logic flag_ff;
	logic nxt_flag;

	always_comb begin
		nxt_flag = set | (flag_ff & ~clr);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_ff <= 1'b0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	assign flag = flag_ff;

endmodule : trc_flag

// File: trc_checker.sv
// trc_checker: bus and timer output assertions for trc_top
module trc_checker #(
	parameter int COUNT_BITS = 8        // counter width option
) (
	input wire logic        ref_clk,     // clock
	input wire logic        arst_n,      // reset
	input wire logic        psel,        // select
	input wire logic        penable,     // enable
	input wire logic        pwrite,      // write
	input wire logic [11:0] paddr,       // address
	input wire logic [31:0] prdata,      // read data
	input wire logic        pready,      // ready
	input wire logic        pslverr,     // error
	input wire logic        irq,         // interrupt
	input wire logic        tone_output, // tone
	input wire logic        tone_oe      // tone pin owner
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	wire logic rd = pready && !pwrite;
	wire logic clr_acc = psel && penable && pwrite && (paddr == trc_pkg::ADDR_CLEAR || paddr == trc_pkg::ADDR_IRQ_EN);
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_unmapped_err: assert property (pready && paddr[9:2] < 8'hd8 |-> pslverr) else $error("unmapped not refused");
	a_reload_reads_zero: assert property (rd && paddr == trc_pkg::ADDR_RELOAD |-> prdata == 32'h0)
		else $error("reload readable");
	a_count_masked: assert property (rd && paddr == trc_pkg::ADDR_COUNT |-> (prdata >> COUNT_BITS) == 0)
		else $error("count above width");
	a_irq_sticky: assert property (irq && !clr_acc && !$past(clr_acc) |=> irq)
		else $error("irq dropped without clear");
	a_tone_pin_owned: assert property (tone_output |-> tone_oe)
		else $error("tone without pin");
endmodule : trc_checker

// File: trc_top_bench.sv
// trc_top_bench: self-checking bench for the reload timer
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_mismatch++; \
	$display("Error %s exp %h got %h", n, e, s); end end
module trc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int COUNT_BITS = 4;
	typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} trc_row_t;
	logic        ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, irq, tone_output, tone_oe;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic        pready, pslverr, e, second_pwm_output;
	int          n_mismatch = 0, check_count = 0, c;
	trc_row_t    rows[7] = '{
		'{trc_pkg::ADDR_IRQ_EN, 32'hffffffff, 32'h3, 0}, '{trc_pkg::ADDR_COUNT, 32'hff, 32'hf, 0},
		'{trc_pkg::ADDR_RELOAD, 32'hab, 32'h0, 0}, '{trc_pkg::ADDR_MODE, 32'h7e, 32'h7e, 0},
		'{trc_pkg::ADDR_CLEAR, 32'h3, 32'h0, 0}, '{trc_pkg::ADDR_STATUS, 32'h3, 32'h0, 0},
		'{12'h004, 32'h5, 32'h0, 1}};
	always #2.5 ref_clk = ~ref_clk;
	trc_top #(.COUNT_BITS(COUNT_BITS)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .tone_output(tone_output), .tone_oe(tone_oe), .second_pwm_output(second_pwm_output));
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do begin @(posedge ref_clk); end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic tgl(input logic p, output int n);
		logic t;
		t = p ? second_pwm_output : tone_output;
		n = 0;
		do begin @(posedge ref_clk); n++; end while ((p ? second_pwm_output : tone_output) === t && n < 20000);
	endtask : tgl
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (60000) @(posedge ref_clk);
		n_mismatch++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		arst_n <= 1;
		`CHK("irq", 1'b0, irq)
		`CHK("tone", 2'b0, {tone_output, tone_oe})
		apb(0, trc_pkg::ADDR_MODE, 0);
		`CHK("mode", 32'h0, q)
		$display("reset test done");
		foreach (rows[i]) begin
			apb(1, rows[i].a, rows[i].w);
			`CHK("werr", rows[i].e, e)
			apb(0, rows[i].a, 0);
			`CHK("rdata", rows[i].r, q)
			`CHK("rerr", rows[i].e, e)
		end
		$display("row test done");
		apb(1, trc_pkg::ADDR_COUNT, 5);
		repeat (40) @(posedge ref_clk);
		apb(0, trc_pkg::ADDR_COUNT, 0);
		`CHK("held", 32'h5, q)
		apb(1, trc_pkg::ADDR_MODE, 0);
		apb(1, trc_pkg::ADDR_IRQ_EN, 1);
		apb(1, trc_pkg::ADDR_COUNT, 32'hf);
		apb(1, trc_pkg::ADDR_MODE, 32'h80);
		repeat (1000) @(posedge ref_clk);
		`CHK("early", 1'b0, irq)
		repeat (60) @(posedge ref_clk);
		`CHK("irq", 1'b1, irq)
		apb(0, trc_pkg::ADDR_COUNT, 0);
		`CHK("wrap", 32'h0, q)
		apb(1, trc_pkg::ADDR_COUNT, 32'hf);
		apb(0, trc_pkg::ADDR_COUNT, 0);
		`CHK("rewrite", 32'hf, q)
		apb(1, trc_pkg::ADDR_MODE, 0);
		apb(0, trc_pkg::ADDR_STATUS, 0);
		`CHK("status", 32'h1, q)
		apb(1, trc_pkg::ADDR_IRQ_EN, 0);
		repeat (2) @(posedge ref_clk);
		`CHK("masked", 1'b0, irq)
		apb(1, trc_pkg::ADDR_IRQ_EN, 1);
		repeat (2) @(posedge ref_clk);
		`CHK("sticky", 1'b1, irq)
		apb(1, trc_pkg::ADDR_CLEAR, 1);
		repeat (2) @(posedge ref_clk);
		`CHK("cleared", 1'b0, irq)
		$display("irq test done");
		apb(1, trc_pkg::ADDR_RELOAD, 8);
		for (int f = 1; f >= 0; f--) begin
			for (int r = 0; r < 8; r++) begin
				apb(1, trc_pkg::ADDR_MODE, {24'h0, 1'b1, r[2:0], f[0], 3'h6});
				tgl(0, c);
				tgl(0, c);
				`CHK("period", 8 * ((f ? 128 : 1024) >> r), c)
				`CHK("tone_oe", 1'b1, tone_oe)
			end
		end
		$display("rate test done");
		apb(1, trc_pkg::ADDR_MODE, 0);
		apb(1, trc_pkg::ADDR_COUNT, 0);
		apb(1, trc_pkg::ADDR_MODE, 32'hf9);
		tgl(1, c);
		if (second_pwm_output === 1'b0) tgl(1, c);
		tgl(1, c);
		`CHK("pwm_high", 8, c)
		tgl(1, c);
		`CHK("pwm_low", 8, c)
		$display("pwm test done");
		arst_n <= 0;
		repeat (2) @(posedge ref_clk);
		`CHK("rst_out", 4'h0, {irq, tone_output, tone_oe, second_pwm_output})
		arst_n <= 1;
		apb(0, trc_pkg::ADDR_STATUS, 0);
		`CHK("rst_status", 32'h0, q)
		$display("mid reset test done");
		wrap_up();
	end
endmodule : trc_top_bench
bind trc_top trc_checker #(.COUNT_BITS(COUNT_BITS)) u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.irq(irq), .tone_output(tone_output), .tone_oe(tone_oe));
